/* File: asmp_params.svh */
// Constants of the asynchronous static memory port
`ifndef ASMP_PARAMS_SVH
`define ASMP_PARAMS_SVH

// Bus geometry defaults
`define ASMP_ADDR_W      20
`define ASMP_DATA_W      16
`define ASMP_REGIONS     4
`define ASMP_REGION_W    2

// Phase lengths in ref_clk cycles, each at least one
`define ASMP_SETUP_CYC   8'h01
`define ASMP_ACCESS_CYC  8'h02
`define ASMP_HOLD_CYC    8'h01
`define ASMP_CNT_W       8

// Byte-lane enable codes, active low, bit 1 is the upper lane
`define ASMP_BE_BOTH_N   2'h0
`define ASMP_BE_UPPER_N  2'h1
`define ASMP_BE_LOWER_N  2'h2
`define ASMP_BE_NONE_N   2'h3

`endif

/* File: asmp_pkg.sv */
// Types shared by the static memory port modules
package asmp_pkg;

    // ==========================================================
    // Access sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_SETUP,
        ST_ACCESS,
        ST_HOLD
    } asmp_state_type;

endpackage

/* File: asmp_timer_if.sv */
// Carrier between the access sequencer and its phase timer
`timescale 1ns/1ps
`include "asmp_params.svh"

interface asmp_timer_if;
    logic                    load;
    logic [`ASMP_CNT_W-1:0]  load_val;
    logic                    done;

    modport seq
    (
        output load,
        output load_val,
        input  done
    );

    modport tmr
    (
        input  load,
        input  load_val,
        output done
    );
endinterface

/* File: asmp_phase_timer.sv */
// Down counter that times the setup, access and hold phases
`timescale 1ns/1ps
`include "asmp_params.svh"

module asmp_phase_timer
(
    input  wire logic  ref_clk,
    input  wire logic  reset,
    asmp_timer_if.tmr  tmr
);

    typedef struct packed
    {
        logic [`ASMP_CNT_W-1:0] cnt;
    } asmp_timer_state_type;

    asmp_timer_state_type st_q;
    asmp_timer_state_type st_d;

    // ==========================================================
    // Next count: a load wins over the countdown
    always_comb
    begin
        st_d = st_q;
        if (tmr.load)
        begin
            st_d.cnt = tmr.load_val;
        end
        else if (st_q.cnt != '0)
        begin
            st_d.cnt = st_q.cnt - `ASMP_CNT_W'(1);
        end
    end

    // Done means the current cycle is the last one of the phase
    assign tmr.done = (st_q.cnt == '0);

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule

/* File: asmp_port.sv */
// Asynchronous static memory port: sequences strobes, selects and lanes
//
// Behaviour
// [RULE_01] Upper-byte write: upper enable low, lower high
// [RULE_02] Lower-byte write: upper enable high, lower low
// [RULE_03] Output enable asserted from first setup cycle
// [RULE_04] Read strobe asserted when access phase starts
// [RULE_05] Write strobe low for whole access period
// [RULE_06] Access waits until external ready is high
// [RULE_07] Only the addressed region select goes low
// [RULE_08] Reads and full writes enable both lanes
`timescale 1ns/1ps
`include "asmp_params.svh"

module asmp_port
#(
    parameter int                    ADDR_W     = `ASMP_ADDR_W,
    parameter int                    DATA_W     = `ASMP_DATA_W,
    parameter int                    REGIONS    = `ASMP_REGIONS,
    parameter int                    REGION_W   = `ASMP_REGION_W,
    parameter logic [`ASMP_CNT_W-1:0] SETUP_CYC  = `ASMP_SETUP_CYC,
    parameter logic [`ASMP_CNT_W-1:0] ACCESS_CYC = `ASMP_ACCESS_CYC,
    parameter logic [`ASMP_CNT_W-1:0] HOLD_CYC   = `ASMP_HOLD_CYC
)
(
    input  wire logic                ref_clk,
    input  wire logic                reset,
    // User request side
    input  wire logic                req_valid,
    input  wire logic                req_write,
    input  wire logic [REGION_W-1:0] req_region,
    input  wire logic [ADDR_W-1:0]   req_addr,
    input  wire logic [DATA_W-1:0]   req_wdata,
    input  wire logic [1:0]          req_byte_en,
    output logic                     req_ready,
    output logic                     rsp_valid,
    output logic [DATA_W-1:0]        rsp_rdata,
    // External memory side
    output logic [ADDR_W-1:0]        ext_addr_bus,
    input  wire logic [DATA_W-1:0]   ext_data_bus_in,
    output logic [DATA_W-1:0]        ext_data_bus_out,
    output logic                     ext_data_bus_oe_n,
    output logic [REGIONS-1:0]       region_select_n,
    output logic                     read_output_strobe_n,
    output logic                     read_strobe_n,
    output logic                     write_strobe_n,
    output logic [1:0]               byte_lane_enable_n,
    input  wire logic                ext_ready_in
);

    // ==========================================================
    // Registered state: every pin below comes straight from a field
    typedef struct packed
    {
        asmp_pkg::asmp_state_type state;
        logic                     is_write;
        logic                     req_ready;
        logic                     rsp_valid;
        logic [DATA_W-1:0]        rsp_rdata;
        logic [ADDR_W-1:0]        addr;
        logic [DATA_W-1:0]        wdata;
        logic                     data_oe_n;
        logic [REGIONS-1:0]       sel_n;
        logic                     oe_n;
        logic                     re_n;
        logic                     we_n;
        logic [1:0]               be_n;
    } asmp_port_state_type;

    asmp_port_state_type st_q;
    asmp_port_state_type st_d;
    asmp_timer_if        tmr_if ();

    // ==========================================================
    // Phase timer; loaded with the phase length minus one
    asmp_phase_timer u_timer
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tmr     (tmr_if.tmr)
    );

    // ==========================================================
    // Access sequencer
    always_comb
    begin
        st_d = st_q;
        st_d.rsp_valid = 1'b0;
        tmr_if.load = 1'b0;
        tmr_if.load_val = '0;
        // Requests are taken only in idle; one arriving while busy waits on
        // req_ready, so the user side needs no queue of its own
        unique case (st_q.state)
            asmp_pkg::ST_IDLE:
            begin
                if (req_valid && st_q.req_ready)
                begin
                    st_d.state = asmp_pkg::ST_SETUP;
                    st_d.req_ready = 1'b0;
                    st_d.is_write = req_write;
                    st_d.addr = req_addr;
                    st_d.wdata = req_wdata;
                    // Only the addressed region's select goes low
                    st_d.sel_n = ~(REGIONS'(1) << req_region); // [RULE_07]
                    if (req_write)
                    begin
                        // Lane enables are the inverted byte mask
                        st_d.be_n = ~req_byte_en; // [RULE_01] [RULE_02] [RULE_08]
                        // A mask of 00 enables no lane, so such a write is harmless.
                        // Data goes on the bus before the write strobe falls and
                        // stays there through hold
                        st_d.data_oe_n = 1'b0;
                    end
                    else
                    begin
                        st_d.be_n = `ASMP_BE_BOTH_N; // [RULE_08]
                        st_d.oe_n = 1'b0; // [RULE_03]
                    end
                    // The timer ends a phase at zero, so N cycles load N-1
                    tmr_if.load = 1'b1;
                    tmr_if.load_val = SETUP_CYC - `ASMP_CNT_W'(1);
                end
            end
            asmp_pkg::ST_SETUP:
            begin
                if (tmr_if.done)
                begin
                    st_d.state = asmp_pkg::ST_ACCESS;
                    if (st_q.is_write)
                    begin
                        st_d.we_n = 1'b0; // [RULE_05]
                    end
                    else
                    begin
                        // Output enable is already low; the strobe joins it
                        st_d.re_n = 1'b0; // [RULE_04]
                    end
                    tmr_if.load = 1'b1;
                    tmr_if.load_val = ACCESS_CYC - `ASMP_CNT_W'(1);
                end
            end
            asmp_pkg::ST_ACCESS:
            begin
                // A slow device stretches the access by holding ready low.
                // Ready is looked at from the last timed access cycle on, so a device
                // that wants to stretch must pull it low by then. Read data is
                // taken on the edge the strobes rise, while the memory drives
                if (tmr_if.done && ext_ready_in) // [RULE_06]
                begin
                    st_d.state = asmp_pkg::ST_HOLD;
                    st_d.we_n = 1'b1; // [RULE_05]
                    st_d.re_n = 1'b1;
                    st_d.oe_n = 1'b1;
                    st_d.rsp_valid = 1'b1;
                    if (!st_q.is_write)
                    begin
                        st_d.rsp_rdata = ext_data_bus_in;
                    end
                    tmr_if.load = 1'b1;
                    tmr_if.load_val = HOLD_CYC - `ASMP_CNT_W'(1);
                end
            end
            asmp_pkg::ST_HOLD:
            begin
                // Strobes are high again, so the memory may let go of the bus
                // Select, address and write data stay put through hold
                if (tmr_if.done)
                begin
                    st_d.state = asmp_pkg::ST_IDLE;
                    st_d.sel_n = '1;
                    st_d.be_n = `ASMP_BE_NONE_N;
                    st_d.data_oe_n = 1'b1;
                    st_d.req_ready = 1'b1;
                end
            end
            // Unused state codes fall back to idle rather than lock up
            default:
            begin
                st_d.state = asmp_pkg::ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // State register; all strobes idle high after reset
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            // Clear everything first, then set the pins that idle high
            st_q <= '0;
            st_q.state <= asmp_pkg::ST_IDLE;
            st_q.req_ready <= 1'b1;
            st_q.data_oe_n <= 1'b1;
            st_q.sel_n <= '1;
            st_q.oe_n <= 1'b1;
            st_q.re_n <= 1'b1;
            st_q.we_n <= 1'b1;
            st_q.be_n <= `ASMP_BE_NONE_N;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs straight from the state register
    // No gates between flops and pins keeps the pin timing clean
    assign req_ready            = st_q.req_ready;
    assign rsp_valid            = st_q.rsp_valid;
    assign rsp_rdata            = st_q.rsp_rdata;
    assign ext_addr_bus         = st_q.addr;
    assign ext_data_bus_out     = st_q.wdata;
    assign ext_data_bus_oe_n    = st_q.data_oe_n;
    assign region_select_n      = st_q.sel_n;
    assign read_output_strobe_n = st_q.oe_n;
    assign read_strobe_n        = st_q.re_n;
    assign write_strobe_n       = st_q.we_n;
    assign byte_lane_enable_n   = st_q.be_n;

endmodule

/* File: asmp_port_chk.sv */
// Checker on the static memory port pins
`timescale 1ns/1ps
module asmp_port_chk
#(
    parameter int REGIONS = 4,
    parameter int REGION_W = 2
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [REGION_W-1:0] req_region,
    input wire logic [1:0] req_byte_en,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [REGIONS-1:0] region_select_n,
    input wire logic read_output_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] byte_lane_enable_n,
    input wire logic ext_ready_in
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Request taken at this edge; setup starts right after
    wire take = req_valid && req_ready;
    // ========
    // Pins against the request that opened the access
    a_upper_lane: assert property (take && req_write && req_byte_en == 2'h2
        |=> byte_lane_enable_n == 2'h1) else $error("upper lane wrong");
    a_lower_lane: assert property (take && req_write && req_byte_en == 2'h1
        |=> byte_lane_enable_n == 2'h2) else $error("lower lane wrong");
    a_both_lanes: assert property (take && (!req_write || req_byte_en == 2'h3)
        |=> byte_lane_enable_n == 2'h0) else $error("both lanes wrong");
    a_oe_setup: assert property (take && !req_write
        |=> !read_output_strobe_n && read_strobe_n) else $error("output enable late");
    a_re_access: assert property (take && !req_write
        |=> ##1 !read_strobe_n && !read_output_strobe_n) else $error("read strobe late");
    a_we_window: assert property (take && req_write
        |=> write_strobe_n ##1 !write_strobe_n [*2]) else $error("write strobe short");
    a_ready_wait: assert property (rsp_valid |-> $past(ext_ready_in))
        else $error("done while not ready");
    a_select_hit: assert property (take
        |=> region_select_n == ~(REGIONS'(1) << $past(req_region))) else $error("bad select");
endmodule

bind asmp_port asmp_port_chk #(.REGIONS(REGIONS), .REGION_W(REGION_W)) i_asmp_port_chk
    (.ref_clk, .reset, .req_valid, .req_write, .req_region, .req_byte_en, .req_ready,
    .rsp_valid, .region_select_n, .read_output_strobe_n, .read_strobe_n, .write_strobe_n,
    .byte_lane_enable_n, .ext_ready_in);

/* File: asmp_sram_model.sv */
// Behavioural asynchronous static memory beyond the port
`timescale 1ns/1ps
module asmp_sram_model
(
    input wire logic [3:0] region_select_n,
    input wire logic read_output_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] byte_lane_enable_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] dq_in,
    input wire logic stall,
    output logic [15:0] dq_out,
    output logic ext_ready_in
);
    logic [15:0] mem [16];
    logic [15:0] last_q = 16'h0;
    wire sel = region_select_n != 4'hf;
    wire drive = sel && !read_output_strobe_n;
    // ========
    // Lanes latch as the write strobe ends; a disabled lane keeps its byte
    always @(posedge write_strobe_n)
        if (sel)
            mem[addr] = {byte_lane_enable_n[1] ? mem[addr][15:8] : dq_in[15:8],
                byte_lane_enable_n[0] ? mem[addr][7:0] : dq_in[7:0]};
    // Released bus shows the inverse of the last word, so stale data never matches
    always @*
        if (drive)
            last_q = mem[addr];
    assign dq_out = drive ? mem[addr] : ~last_q;
    assign ext_ready_in = !stall;
endmodule

/* File: testbench.sv */
// Self-checking bench for the static memory port
`timescale 1ns/1ps
`include "asmp_params.svh"
module testbench;
    logic ref_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic [1:0] req_region = 2'h0, req_byte_en = 2'h0, byte_lane_enable_n;
    logic [15:0] req_wdata = 16'h0, rsp_rdata, ext_data_bus_out, mem_q;
    logic [19:0] ext_addr_bus;
    logic [3:0] region_select_n;
    logic req_ready, rsp_valid, ext_data_bus_oe_n, read_output_strobe_n;
    logic read_strobe_n, write_strobe_n, ext_ready_in;
    logic stall_load = 1'b0;
    int num_errors = 0, check_count = 0, cycles = 0, hold_cnt = 0, lat;
    wire [19:0] req_addr = {18'h0, req_region};
    wire stall = hold_cnt != 0;
    // Port drives the data wire on writes only, the memory otherwise
    wire [15:0] bus = ext_data_bus_oe_n ? mem_q : ext_data_bus_out;
    // Free-running clock, 100 ns period
    always #50 ref_clk = ~ref_clk;
    asmp_port i_asmp_port (.ref_clk, .reset, .req_valid, .req_write, .req_region, .req_addr,
        .req_wdata, .req_byte_en, .req_ready, .rsp_valid, .rsp_rdata, .ext_addr_bus,
        .ext_data_bus_in(bus), .ext_data_bus_out, .ext_data_bus_oe_n, .region_select_n,
        .read_output_strobe_n, .read_strobe_n, .write_strobe_n, .byte_lane_enable_n,
        .ext_ready_in);
    asmp_sram_model i_asmp_sram_model (.region_select_n, .read_output_strobe_n,
        .write_strobe_n, .byte_lane_enable_n, .addr(ext_addr_bus[3:0]), .dq_in(bus),
        .stall, .dq_out(mem_q), .ext_ready_in);
    // ========
    // Verdict and comparison
    task automatic end_sim;
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One transfer; lat counts cycles from acceptance to the response
    task automatic xfer(input logic w, input logic [1:0] r, input logic [15:0] d,
        input logic [1:0] be);
        @(posedge ref_clk);
        #10;
        req_valid = 1'b1;
        req_write = w;
        req_region = r;
        req_wdata = d;
        req_byte_en = be;
        @(posedge ref_clk);
        #10;
        req_valid = 1'b0;
        lat = 0;
        while (rsp_valid !== 1'b1 && lat < 40)
        begin
            @(posedge ref_clk);
            #10;
            lat++;
        end
        chk({15'h0, rsp_valid}, 16'h0001);
    endtask
    // Partial writes touch only their own byte of the word
    task automatic t_lanes;
        xfer(1'b1, 2'h1, 16'h1234, 2'h3);
        xfer(1'b1, 2'h1, 16'hab00, 2'h2);
        xfer(1'b1, 2'h1, 16'h00cd, 2'h1);
        xfer(1'b0, 2'h1, 16'h0000, 2'h0);
        chk(rsp_rdata, 16'habcd);
    endtask
    // Each region selects its own chip; reads answer after setup plus access
    task automatic t_regions;
        for (int r = 0; r < 4; r++)
        begin
            xfer(1'b0, 2'(r), 16'h0000, 2'h0);
            chk({12'h0, region_select_n}, {12'h0, ~(4'h1 << r)});
            chk(16'(lat), 16'(`ASMP_SETUP_CYC + `ASMP_ACCESS_CYC));
            chk(ext_addr_bus[15:0], 16'(r));
            chk({13'h0, read_output_strobe_n, read_strobe_n, write_strobe_n}, 16'h0007);
        end
    endtask
    // A slow memory holds the write until it is ready again
    task automatic t_stall;
        stall_load = 1'b1;
        @(posedge ref_clk);
        #10;
        stall_load = 1'b0;
        xfer(1'b1, 2'h2, 16'h5a5a, 2'h3);
        chk(16'(lat > 6), 16'h0001);
        xfer(1'b0, 2'h2, 16'h0000, 2'h0);
        chk(rsp_rdata, 16'h5a5a);
    endtask
    // Hang guard, far above the fewer than a hundred cycles needed, and stall countdown
    always @(posedge ref_clk)
    begin
        cycles++;
        if (stall_load)
            hold_cnt <= 8;
        else
            hold_cnt <= (hold_cnt > 0) ? hold_cnt - 1 : 0;
        if (cycles == 2000)
        begin
            num_errors++;
            end_sim;
        end
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge ref_clk);
        #10;
        reset = 1'b0;
        t_lanes;
        t_regions;
        t_stall;
        end_sim;
    end
endmodule
